// *** logic/mpc_regs.svh ***
// Register offsets, field positions, reset values and timing counts for the phase/mode controller
`ifndef MPC_REGS_SVH
`define MPC_REGS_SVH

`define MPC_ADDR_W        12
`define MPC_REG_CTRL      12'h000
`define MPC_REG_DUTY      12'h004
`define MPC_REG_OCBASE    12'h008
`define MPC_REG_STATUS    12'h00c
`define MPC_REG_TARGET    12'h010

`define MPC_CTRL_ENABLE   0
`define MPC_CTRL_RST      1'b0
`define MPC_DUTY_RST      8'h1c
`define MPC_OCBASE_RST    12'h600

`define MPC_CLK_NS        40
`define MPC_OC_DELAY_US   120
`define MPC_OC_DELAY_CYC  ((`MPC_OC_DELAY_US * 1000 + `MPC_CLK_NS - 1) / `MPC_CLK_NS)
`define MPC_WAY_NUM       5
`define MPC_WAY_SHIFT     1
`define MPC_SLEW_NS       100
`define MPC_SLEW_CYC      ((`MPC_SLEW_NS + `MPC_CLK_NS - 1) / `MPC_CLK_NS)
`define MPC_RAMP_NEAR     8
`define MPC_VID_TOP       3000
`define MPC_VID_STEP      25
`define MPC_VID_ZERO      120
`define MPC_DIP_MV        20
`define MPC_DIP_LSB       (`MPC_DIP_MV * 2)
`define MPC_FILT_NS       100
`define MPC_FILT_SHIFT    1
`define MPC_DCM_CYCLES    4
`define MPC_STRAP_SETTLE  4

`endif

// *** logic/mpc_pkg.sv ***
// Types shared by the phase/mode controller
package mpc_pkg;
  typedef enum logic [1:0] {CFG_THREE, CFG_TWO, CFG_ONE} phase_cfg_t;
  typedef struct packed {
    logic [1:0] phases;
    logic       diodeEmu;
  } op_mode_t;
  typedef struct packed {
    logic [2:0] drive;
    logic [2:0] enable;
  } pwm_pins_t;
  typedef enum logic {ST_STRAP, ST_RUN} ctl_state_t;
endpackage

// *** logic/vid_ramp.sv ***
// Reference ramp that slews the regulation target toward the voltage code level
`timescale 1ns/1ps
`default_nettype none
`include "mpc_regs.svh"
module vid_ramp (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Requested code, synchronised
  input  wire logic [6:0]  code,
  // Ramp state
  output logic      [11:0] target,
  output logic             rising,
  output logic             settled
);
  logic [11:0] level_q, level_d;
  logic [2:0]  div_q, div_d;
  logic        rising_q, rising_d;
  logic        settled_q, settled_d;
  logic [11:0] goal;
  logic [11:0] diff;

  // Code to target in 0.5 mV units; top codes all mean zero volts
  function automatic logic [11:0] codeToLevel(input logic [6:0] c);
    if (c >= 7'(`MPC_VID_ZERO)) return 12'h000;
    return 12'(`MPC_VID_TOP - `MPC_VID_STEP * int'(c));
  endfunction

  // One 0.5 mV step per slew period, half rate near the goal to avoid overshoot
  always_comb begin
    goal      = codeToLevel(code);
    diff      = (goal > level_q) ? goal - level_q : level_q - goal;
    level_d   = level_q;
    div_d     = div_q;
    rising_d  = goal > level_q;
    settled_d = goal == level_q;
    if (div_q != 3'h0) begin
      div_d = div_q - 3'h1;
    end else if (goal != level_q) begin
      level_d = (goal > level_q) ? level_q + 12'h001 : level_q - 12'h001;
      div_d   = (diff <= 12'(`MPC_RAMP_NEAR)) ? 3'(2 * `MPC_SLEW_CYC - 1)
                                              : 3'(`MPC_SLEW_CYC - 1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level_q   <= 12'h000;
      div_q     <= 3'h0;
      rising_q  <= 1'b0;
      settled_q <= 1'b0;
    end else begin
      level_q   <= level_d;
      div_q     <= div_d;
      rising_q  <= rising_d;
      settled_q <= settled_d;
    end
  end

  assign target  = level_q;
  assign rising  = rising_q;
  assign settled = settled_q;
endmodule
`default_nettype wire

// *** logic/fast_dip_detect.sv ***
// Fast voltage dip detector that asks for an extra switching cycle
`timescale 1ns/1ps
`default_nettype none
`include "mpc_regs.svh"
module fast_dip_detect (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Sensed output voltage, 0.5 mV units, same clock
  input  wire logic [11:0] sense,
  // One-cycle request for an extra cycle
  output logic             dipPulse
);
  logic [11:0] filt_q, filt_d;
  logic        dip_q, dip_d;
  logic        pulse_q, pulse_d;
  logic signed [12:0] delta;

  // First-order filter, time constant near 100 ns at this clock
  always_comb begin
    delta   = $signed({1'b0, sense}) - $signed({1'b0, filt_q});
    filt_d  = 12'($signed({1'b0, filt_q}) + (delta >>> `MPC_FILT_SHIFT));
    dip_d   = (filt_q > sense) && ((filt_q - sense) >= 12'(`MPC_DIP_LSB));
    pulse_d = dip_d & ~dip_q; // One request per dip, not one per cycle
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      filt_q  <= 12'h000;
      dip_q   <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      filt_q  <= filt_d;
      dip_q   <= dip_d;
      pulse_q <= pulse_d;
    end
  end

  assign dipPulse = pulse_q;
endmodule
`default_nettype wire

// *** logic/multiphase_mode_control.sv ***
// Phase count and operating mode control of a multiphase buck controller
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "mpc_regs.svh"
// Function
// - Phase3 strap high: two phases, antiphase
// - Both straps high: single phase only
// - Two-phase config: third sense is feedback
// - Three-phase: power-state selects three or two
// - Two of three phases: thresholds two thirds
// - Three-phase sleep: one phase, one third
// - Two-phase config: low state halves, one phase
// - Two-phase sleep: diode emulation, drop phase2
// - Single-phase config ignores power-state signal
// - Target slews 0.5mV per 120ns, slower near goal
// - Diode emulation: rising code drives actively
// - Discontinuous after four zero-crossing cycles
// - Diode emulation: falling code stays passive
// - 20mV dip below filtered: extra cycle
// - Trim pulse widths to equalise sense
// - Overcurrent after 120us continuous excess
// - Above 2.5x threshold: shut off immediately
module multiphase_mode_control
  import mpc_pkg::*;
#(
  parameter int PWM_PERIOD = 84,
  parameter int TRIM_SHIFT = 2
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Processor pins, asynchronous
  input  wire logic        powerStateLowN,
  input  wire logic        deeperSleepRequest,
  input  wire logic [6:0]  voltageSelectCode,
  // Strap and comparator pins, asynchronous
  input  wire logic        phase3PwmIn,
  input  wire logic        phase2SenseStrap,
  input  wire logic        zeroCrossIn,
  // Converter samples, same clock
  input  wire logic [11:0] phase1CurrentSense,
  input  wire logic [11:0] phase2CurrentSense,
  input  wire logic [11:0] phase3CurrentSense,
  input  wire logic [11:0] droopCurrent,
  input  wire logic [11:0] outputVoltageSense,
  // Power stage and status outputs
  output pwm_pins_t        pwmPins,
  output logic             powerGood,
  output logic             secondaryFeedbackSel,
  output logic             fastClockPulse,
  output logic      [11:0] dacTarget,
  output op_mode_t         opMode
);
  localparam int OC_CYC = `MPC_OC_DELAY_CYC;

  logic [11:0] meta_q, sync_q;
  logic        zcPrev_q;
  logic        psiN, sleepReq, zcEdge;
  logic [6:0]  codeSync;
  logic        rampRising, rampSettled, dipPulse;
  logic [11:0] rampTarget;

  ctl_state_t  state_q, state_d;
  logic [2:0]  settle_q, settle_d;
  phase_cfg_t  cfg_q, cfg_d;
  logic        enable_q, enable_d;
  logic [7:0]  duty_q, duty_d;
  logic [11:0] ocBase_q, ocBase_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;

  logic [7:0]  cnt_q, cnt_d;
  logic        zcSeen_q, zcSeen_d;
  logic [2:0]  zcRun_q, zcRun_d;
  logic [7:0]  dutyEff_q [3];
  logic [7:0]  dutyEff_d [3];
  pwm_pins_t   pins_q, pins_d;
  op_mode_t    mode_q, mode_d;

  logic [11:0] ocCnt_q, ocCnt_d;
  logic        ocFault_q, ocFault_d;
  logic        wayFault_q, wayFault_d;
  logic        power_good_q, power_good_d;

  logic        run, cycStart, discontinuous_conduction, access;
  logic [13:0] avg, thr, way;
  logic [31:0] status;

  function automatic logic [1:0] cfgPhases(input phase_cfg_t c);
    case (c)
      CFG_THREE: return 2'd3;
      CFG_TWO:   return 2'd2;
      default:   return 2'd1;
    endcase
  endfunction

  // Operating mode table
  function automatic op_mode_t decodeMode(input phase_cfg_t c, input logic pn, input logic dpr);
    op_mode_t m;
    m.diodeEmu = dpr;
    case (c)
      CFG_THREE: m.phases = dpr ? 2'd1 : (pn ? 2'd3 : 2'd2);
      CFG_TWO:   m.phases = dpr ? 2'd1 : (pn ? 2'd2 : 2'd1);
      default:   m.phases = 2'd1;
    endcase
    return m;
  endfunction

  // Threshold scaled by active over configured phases
  function automatic logic [13:0] scaleThr(input logic [11:0] b, input logic [1:0] act,
                                           input logic [1:0] cfgN);
    logic [15:0] p;
    p = 16'(b) * 16'(act);
    case (cfgN)
      2'd3:    return 14'(p / 16'd3);
      2'd2:    return 14'(p / 16'd2);
      default: return 14'(p);
    endcase
  endfunction

  function automatic logic [7:0] phaseOffset(input int i, input logic [1:0] n);
    if (n == 2'd0) return 8'h00;
    return 8'((i * PWM_PERIOD) / int'(n));
  endfunction

  function automatic logic phaseOn(input logic [7:0] c, input logic [7:0] off,
                                   input logic [7:0] d);
    logic [7:0] rel;
    rel = (c >= off) ? c - off : 8'(int'(c) + PWM_PERIOD - int'(off));
    return rel < d;
  endfunction

  function automatic logic [7:0] applyTrim(input logic [7:0] d, input logic [11:0] s,
                                           input logic [13:0] a);
    logic signed [14:0] t;
    t = $signed({7'h00, d}) + (($signed({1'b0, a}) - $signed({3'b000, s})) >>> TRIM_SHIFT);
    if (t < 15'sd0) return 8'h00;
    if (t > 15'(PWM_PERIOD - 1)) return 8'(PWM_PERIOD - 1);
    return t[7:0];
  endfunction

  // Two-stage synchronisers on every pin input
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q   <= 12'h000;
      sync_q   <= 12'h000;
      zcPrev_q <= 1'b0;
    end else begin
      meta_q   <= {powerStateLowN, deeperSleepRequest, zeroCrossIn, phase3PwmIn,
                   phase2SenseStrap, voltageSelectCode};
      sync_q   <= meta_q;
      zcPrev_q <= sync_q[9];
    end
  end

  assign psiN     = sync_q[11];
  assign sleepReq = sync_q[10];
  assign zcEdge   = sync_q[9] & ~zcPrev_q;
  assign codeSync = sync_q[6:0];

  vid_ramp u_ramp (
    .clk     (clk),
    .rstn    (rstn),
    .code    (codeSync),
    .target  (rampTarget),
    .rising  (rampRising),
    .settled (rampSettled)
  );

  fast_dip_detect u_dip (
    .clk      (clk),
    .rstn     (rstn),
    .sense    (outputVoltageSense),
    .dipPulse (dipPulse)
  );

  // Strap capture and APB register file
  assign access = psel & penable;
  assign status = {20'h00000, state_q == ST_RUN, rampSettled, rampRising, power_good_q,
                   wayFault_q, ocFault_q, discontinuous_conduction, mode_q.diodeEmu, mode_q.phases, cfg_q};
  always_comb begin
    state_d   = state_q;
    settle_d  = settle_q;
    cfg_d     = cfg_q;
    enable_d  = enable_q;
    duty_d    = duty_q;
    ocBase_d  = ocBase_q;
    pready_d  = access & ~pready_q;
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    case (state_q)
      ST_STRAP: begin
        settle_d = settle_q + 3'h1;
        if (settle_q == 3'(`MPC_STRAP_SETTLE - 1)) begin
          state_d = ST_RUN;
          cfg_d   = !sync_q[8] ? CFG_THREE : (sync_q[7] ? CFG_ONE : CFG_TWO);
        end
      end
      ST_RUN:  state_d = ST_RUN;
      default: state_d = ST_STRAP;
    endcase
    if (access & ~pready_q) begin
      pslverr_d = 1'b0;
      case (paddr)
        `MPC_REG_CTRL:   prdata_d = {31'h0, enable_q};
        `MPC_REG_DUTY:   prdata_d = {24'h0, duty_q};
        `MPC_REG_OCBASE: prdata_d = {20'h0, ocBase_q};
        `MPC_REG_STATUS: prdata_d = status;
        `MPC_REG_TARGET: prdata_d = {20'h0, rampTarget};
        default: begin
          prdata_d  = 32'h0;
          pslverr_d = 1'b1;
        end
      endcase
    end
    if (access & pready_q & pwrite) begin
      case (paddr)
        `MPC_REG_CTRL:   enable_d = pwdata[`MPC_CTRL_ENABLE];
        `MPC_REG_DUTY:   duty_d   = pwdata[7:0];
        `MPC_REG_OCBASE: ocBase_d = pwdata[11:0];
        default:         enable_d = enable_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= ST_STRAP;
      settle_q  <= 3'h0;
      cfg_q     <= CFG_THREE;
      enable_q  <= `MPC_CTRL_RST;
      duty_q    <= `MPC_DUTY_RST;
      ocBase_q  <= `MPC_OCBASE_RST;
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      settle_q  <= settle_d;
      cfg_q     <= cfg_d;
      enable_q  <= enable_d;
      duty_q    <= duty_d;
      ocBase_q  <= ocBase_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Mode, balancing, light-load detection and phase pulses
  assign run      = (state_q == ST_RUN) & enable_q & ~ocFault_q & ~wayFault_q;
  assign cycStart = cnt_q == 8'h00;
  assign discontinuous_conduction      = mode_q.diodeEmu & (zcRun_q >= 3'(`MPC_DCM_CYCLES));
  always_comb begin
    mode_d = decodeMode(cfg_q, psiN, sleepReq);
    // Rising code in emulation switches actively until the level is reached
    if (rampRising) mode_d.diodeEmu = 1'b0;
    cnt_d = (dipPulse || cnt_q == 8'(PWM_PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
    zcSeen_d = zcEdge | (zcSeen_q & ~cycStart);
    zcRun_d  = zcRun_q;
    if (cycStart) begin
      zcRun_d = !zcSeen_q ? 3'h0 : (zcRun_q == 3'h7 ? zcRun_q : zcRun_q + 3'h1);
    end
    case (mode_q.phases)
      2'd3:    avg = 14'((16'(phase1CurrentSense) + 16'(phase2CurrentSense)
                          + 16'(phase3CurrentSense)) / 16'd3);
      2'd2:    avg = 14'((16'(phase1CurrentSense) + 16'(phase2CurrentSense)) / 16'd2);
      default: avg = 14'(phase1CurrentSense);
    endcase
    for (int i = 0; i < 3; i++) begin
      dutyEff_d[i] = dutyEff_q[i];
    end
    if (cycStart) begin
      dutyEff_d[0] = applyTrim(duty_q, phase1CurrentSense, avg);
      dutyEff_d[1] = applyTrim(duty_q, phase2CurrentSense, avg);
      // The third sense pin is feedback in two-phase configuration; its trim is still computed but drives no phase there
      dutyEff_d[2] = applyTrim(duty_q, phase3CurrentSense, avg);
    end
    if (mode_q.phases == 2'd1) begin
      dutyEff_d[0] = duty_q;
    end
    for (int i = 0; i < 3; i++) begin
      pins_d.drive[i]  = run & (i < int'(mode_q.phases))
                       & phaseOn(cnt_q, phaseOffset(i, mode_q.phases), dutyEff_q[i]);
      // Dropped phases and discontinuous-conduction off-time float at the mid level
      pins_d.enable[i] = run & (i < int'(mode_q.phases)) & (pins_d.drive[i] | ~discontinuous_conduction);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q   <= '0;
      cnt_q    <= 8'h00;
      zcSeen_q <= 1'b0;
      zcRun_q  <= 3'h0;
      pins_q   <= '0;
      for (int i = 0; i < 3; i++) begin
        dutyEff_q[i] <= 8'h00;
      end
    end else begin
      mode_q   <= mode_d;
      cnt_q    <= cnt_d;
      zcSeen_q <= zcSeen_d;
      zcRun_q  <= zcRun_d;
      pins_q   <= pins_d;
      for (int i = 0; i < 3; i++) begin
        dutyEff_q[i] <= dutyEff_d[i];
      end
    end
  end

  // Overcurrent protection; faults hold until software drops the enable
  assign thr = scaleThr(ocBase_q, mode_q.phases, cfgPhases(cfg_q));
  assign way = 14'((16'(thr) * 16'(`MPC_WAY_NUM)) >> `MPC_WAY_SHIFT);
  always_comb begin
    ocCnt_d = (run && 14'(droopCurrent) > thr) ? ocCnt_q + 12'h001 : 12'h000;
    ocFault_d  = (ocCnt_q == 12'(OC_CYC - 1) && 14'(droopCurrent) > thr)
               | (ocFault_q & enable_q);
    wayFault_d = (run && 14'(droopCurrent) > way) | (wayFault_q & enable_q);
    power_good_d    = run & ~ocFault_d & ~wayFault_d;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ocCnt_q    <= 12'h000;
      ocFault_q  <= 1'b0;
      wayFault_q <= 1'b0;
      power_good_q    <= 1'b0;
    end else begin
      ocCnt_q    <= ocCnt_d;
      ocFault_q  <= ocFault_d;
      wayFault_q <= wayFault_d;
      power_good_q    <= power_good_d;
    end
  end

  // Feedback select follows the latched configuration
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      secondaryFeedbackSel <= 1'b0;
    end else begin
      secondaryFeedbackSel <= cfg_q == CFG_TWO;
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign pwmPins        = pins_q;
  assign powerGood      = power_good_q;
  assign fastClockPulse = dipPulse;
  assign dacTarget      = rampTarget;
  assign opMode         = mode_q;
endmodule
`default_nettype wire

// *** test/mpc_proc_model.sv ***
// Processor-side model driving the power-state, sleep and voltage code pins
`timescale 1ns/1ps
`default_nettype none
module mpc_proc_model #(
  parameter int STEP_CYC = 63
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Requests from the bench
  input  wire logic       fullReq,
  input  wire logic       sleepReq,
  input  wire logic [6:0] codeReq,
  // Pins toward the controller
  output logic            powerStateLowN,
  output logic            deeperSleepRequest,
  output logic      [6:0] voltageSelectCode
);
  int gapQ;
  // Boot code is applied in reset; later the code moves one step per 2.5 us at most
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gapQ               <= 0;
      voltageSelectCode  <= codeReq;
      powerStateLowN     <= 1'b1;
      deeperSleepRequest <= 1'b0;
    end else begin
      powerStateLowN     <= fullReq;
      deeperSleepRequest <= sleepReq;
      gapQ               <= (gapQ > 0) ? gapQ - 1 : 0;
      if (gapQ == 0 && codeReq != voltageSelectCode) begin
        gapQ              <= STEP_CYC;
        voltageSelectCode <= (codeReq > voltageSelectCode) ? voltageSelectCode + 7'h01
                                                           : voltageSelectCode - 7'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/multiphase_mode_control_chk.sv ***
// Concurrent checks on the phase/mode controller ports
`timescale 1ns/1ps
`default_nettype none
module multiphase_mode_control_chk
  import mpc_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // Mode pins and outputs
  input wire logic        powerStateLowN,
  input wire logic        deeperSleepRequest,
  input wire logic [11:0] outputVoltageSense,
  input wire pwm_pins_t   pwmPins,
  input wire logic        secondaryFeedbackSel,
  input wire logic        fastClockPulse,
  input wire logic [11:0] dacTarget,
  input wire op_mode_t    opMode
);
  logic [4:0] upQ;
  logic [4:0] upD;
  logic       up;
  // Age since reset; straps and synchronisers are settled before it saturates
  always_comb begin
    upD = (upQ == 5'h1f) ? upQ : upQ + 5'h01;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      upQ <= 5'h00;
    end else begin
      upQ <= upD;
    end
  end
  assign up = (upQ == 5'h1f);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Mode pins held long enough to pass the synchroniser and decode
  sequence sleepHeld; (up && deeperSleepRequest)[*4]; endsequence
  sequence twoFull; (up && secondaryFeedbackSel && powerStateLowN && !deeperSleepRequest)[*4];
  endsequence
  sequence twoLow; (up && secondaryFeedbackSel && !powerStateLowN && !deeperSleepRequest)[*4];
  endsequence
  sequence vsSteady; $stable(outputVoltageSense)[*8]; endsequence
  a_apb_one_wait: assert property (psel && $rose(penable) |=> pready ##1 !pready)
    else $error("pready not one cycle after access start");
  a_unmapped_err: assert property (pready |-> pslverr == (paddr > 12'h010))
    else $error("pslverr does not match address map");
  a_sleep_one_phase: assert property (sleepHeld |-> opMode.phases == 2'd1)
    else $error("sleep request did not give one phase");
  a_two_cfg_limit: assert property (up && secondaryFeedbackSel |-> opMode.phases != 2'd3 && !pwmPins.enable[2])
    else $error("third phase active in two-phase configuration");
  a_two_cfg_full: assert property (twoFull |-> opMode.phases == 2'd2 && !opMode.diodeEmu)
    else $error("two-phase configuration not running both phases");
  a_two_cfg_low: assert property (twoLow |-> opMode.phases == 2'd1 && !opMode.diodeEmu)
    else $error("low power state did not give one phase");
  a_dropped_tristate: assert property ((opMode.phases == 2'd1)[*2] |-> pwmPins.enable[2:1] == 2'b00)
    else $error("dropped phase still driven");
  a_ramp_hold: assert property ($changed(dacTarget) |=> $stable(dacTarget)[*2])
    else $error("target stepped faster than the slew rate");
  a_ramp_step: assert property ($changed(dacTarget) |-> dacTarget - $past(dacTarget) == 12'h001
                                || $past(dacTarget) - dacTarget == 12'h001)
    else $error("target step not one unit");
  a_dip_clock: assert property (vsSteady ##1 (up && $past(outputVoltageSense) >= outputVoltageSense + 12'h050)
                                |-> ##[1:3] fastClockPulse)
    else $error("voltage dip gave no extra clock");
endmodule
bind multiphase_mode_control multiphase_mode_control_chk multiphase_mode_control_chk_i (
  .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .powerStateLowN(powerStateLowN), .deeperSleepRequest(deeperSleepRequest),
  .outputVoltageSense(outputVoltageSense), .pwmPins(pwmPins),
  .secondaryFeedbackSel(secondaryFeedbackSel), .fastClockPulse(fastClockPulse),
  .dacTarget(dacTarget), .opMode(opMode));
`default_nettype wire

// *** test/multiphase_mode_control_tb.sv ***
// Self-checking bench for the phase/mode controller
`timescale 1ns/1ps
`default_nettype none
`include "mpc_regs.svh"
module multiphase_mode_control_tb
  import mpc_pkg::*;
;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, fullReq = 1, sleepReq = 0;
  logic [11:0] paddr = 12'h000, vsense = 12'h7d0, droop = 12'h000, sns = 12'h100;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, ps, ds, p3 = 0, p2 = 0, pg, fbSel, dip, saw, zcOn = 0;
  logic [6:0]  codeReq = 7'h64, vcode;
  logic [11:0] dacTarget;
  pwm_pins_t   pwmPins;
  op_mode_t    opMode;
  int          n_errors = 0, n_checks = 0, cycles = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  mpc_proc_model mpc_proc_model_i (.clk(clk), .rstn(rstn), .fullReq(fullReq), .sleepReq(sleepReq),
    .codeReq(codeReq), .powerStateLowN(ps), .deeperSleepRequest(ds), .voltageSelectCode(vcode));
  multiphase_mode_control #(.PWM_PERIOD(12)) multiphase_mode_control_i (.clk(clk), .rstn(rstn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .powerStateLowN(ps),
    .deeperSleepRequest(ds), .voltageSelectCode(vcode), .phase3PwmIn(p3), .phase2SenseStrap(p2),
    .zeroCrossIn(zcOn && cycles % 12 == 0), .phase1CurrentSense(sns), .phase2CurrentSense(sns),
    .phase3CurrentSense(sns), .droopCurrent(droop), .outputVoltageSense(vsense),
    .pwmPins(pwmPins), .powerGood(pg), .secondaryFeedbackSel(fbSel), .fastClockPulse(dip),
    .dacTarget(dacTarget), .opMode(opMode));
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    chk("pready pulse", 32'h0, {31'h0, pready});
  endtask
  // Straps are board levels held across reset; the ramp is left to settle
  task automatic do_reset(input logic s3, input logic s2);
    rstn <= 1'b0; p3 <= s3; p2 <= s2;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (2000) @(posedge clk);
  endtask
  task automatic t_regs();
    apb(0, 12'h000, 0); chk("ctrl", 32'h0, rd);
    apb(0, 12'h004, 0); chk("duty", 32'h1c, rd);
    apb(0, 12'h008, 0); chk("ocbase", 32'h600, rd);
    apb(1, 12'h004, 32'h30); apb(0, 12'h004, 0); chk("duty wr", 32'h30, rd);
    apb(0, 12'h020, 0); chk("unmapped", 32'h80000000, {err, rd[30:0]});
  endtask
  // Walk the four pin combinations; table packs expected phase counts by {power, sleep}
  task automatic t_modes(input logic [7:0] tbl, input logic two);
    logic [1:0] ph;
    logic [3:0] m;
    apb(1, 12'h000, 32'h1);
    for (int i = 0; i < 4; i++) begin
      fullReq <= i[1]; sleepReq <= i[0];
      repeat (6) @(posedge clk);
      ph = tbl[2*i +: 2];
      m = (4'h1 << ph) - 4'h1;
      chk("phases", {30'h0, ph}, {30'h0, opMode.phases});
      chk("diode emu", {31'h0, i[0]}, {31'h0, opMode.diodeEmu});
      chk("enables", {29'h0, m[2:0]}, {29'h0, pwmPins.enable});
      chk("fb select", {31'h0, two}, {31'h0, fbSel});
    end
  endtask
  task automatic t_straps();
    p3 <= 1'b1;
    repeat (20) @(posedge clk);
    chk("strap held", 32'h0, {31'h0, fbSel});
    zcOn <= 1;
    repeat (80) @(posedge clk);
    apb(0, 12'h00c, 0);
    zcOn <= 0;
    chk("light load", 32'h1, {31'h0, rd[5]});
  endtask
  // Code up in diode emulation drives actively, code down stays passive
  task automatic t_ramp();
    saw = 0; codeReq <= 7'h63;
    for (int t = 0; t < 300 && dacTarget !== 12'h20d; t++) begin
      @(posedge clk);
      saw |= (opMode.diodeEmu === 1'b0);
    end
    chk("rise active", 32'h1, {31'h0, saw});
    repeat (10) @(posedge clk);
    chk("rise end", 32'h120d, {19'h0, opMode.diodeEmu, dacTarget});
    saw = 0; codeReq <= 7'h65;
    for (int t = 0; t < 400 && dacTarget !== 12'h1db; t++) begin
      @(posedge clk);
      saw |= (opMode.diodeEmu !== 1'b1);
    end
    chk("fall passive", 32'h11db, {19'h0, !saw, dacTarget});
  endtask
  task automatic t_dip();
    saw = 0; vsense <= 12'h7c0;
    repeat (5) begin @(posedge clk); saw |= dip; end
    chk("small dip", 32'h0, {31'h0, saw});
    vsense <= 12'h7d0;
    repeat (20) @(posedge clk);
    vsense <= 12'h780;
    repeat (5) begin @(posedge clk); saw |= dip; end
    chk("large dip", 32'h1, {31'h0, saw});
    vsense <= 12'h7d0;
  endtask
  // Way limit scales with phase count; slow limit needs the full delay
  task automatic t_oc();
    sleepReq <= 0; fullReq <= 1;
    repeat (6) @(posedge clk);
    droop <= 12'hbb8;
    repeat (20) @(posedge clk);
    chk("no way fault", 32'h7, {29'h0, pwmPins.enable});
    fullReq <= 0;
    repeat (10) @(posedge clk);
    apb(0, 12'h00c, 0);
    chk("way fault", 32'h1, {24'h0, pwmPins.enable, pg, 1'b0, rd[7]});
    fullReq <= 1; droop <= 12'h640;
    apb(1, 12'h000, 0); apb(1, 12'h000, 1);
    repeat (`MPC_OC_DELAY_CYC - 20) @(posedge clk);
    apb(0, 12'h00c, 0); chk("oc early", 32'h0, {31'h0, rd[6]});
    repeat (40) @(posedge clk);
    apb(0, 12'h00c, 0); chk("oc late", 32'h1, {28'h0, pwmPins.enable, rd[6]});
    droop <= 12'h000;
    apb(1, 12'h000, 0); apb(1, 12'h000, 1);
  endtask
  initial begin
    do_reset(0, 0);
    t_regs();
    t_modes(8'h76, 1'b0);
    t_straps();
    t_ramp();
    t_dip();
    t_oc();
    do_reset(1, 0);
    t_modes(8'h65, 1'b1);
    do_reset(1, 1);
    t_modes(8'h55, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
